// >>> bench/cma_assertions.sv
// checker of the external code bus timing at the block's pins
`timescale 1ns/1ns

module cma_assertions (
    // clock and reset
    input wire logic       CLK_SYS,
    input wire logic       RST,
    // external code bus
    input wire logic [7:0] LOW_PORT_OUT,
    input wire logic       LOW_PORT_OE,
    input wire logic [7:0] HIGH_PORT_OUT,
    input wire logic       ADDR_LATCH_EN,
    input wire logic       CODE_FETCH_STROBE_N
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    // latch strobe only while the low address is driven
    ale_drives_a: assert property (ADDR_LATCH_EN |-> LOW_PORT_OE)
        else $error("latch strobe without low address driven");
    // low address held while the latch strobe stays up
    low_hold_a: assert property (ADDR_LATCH_EN && $past(ADDR_LATCH_EN) |-> $stable(LOW_PORT_OUT))
        else $error("low address moved under latch strobe");
    // port released while memory drives data
    low_release_a: assert property (!CODE_FETCH_STROBE_N |-> !LOW_PORT_OE)
        else $error("low port driven during fetch strobe");
    // strobes never active together
    strobe_excl_a: assert property (ADDR_LATCH_EN |-> CODE_FETCH_STROBE_N)
        else $error("fetch strobe during latch strobe");
    // high address frozen for five clocks after the latch strobe rises
    high_hold_a: assert property ($rose(ADDR_LATCH_EN) |=> $stable(HIGH_PORT_OUT)[*5])
        else $error("high address moved in bus cycle");
    // fetch strobe lasts four cpu phases
    strobe_len_a: assert property ($fell(CODE_FETCH_STROBE_N) |->
        (!CODE_FETCH_STROBE_N[*4] ##1 CODE_FETCH_STROBE_N) or
        (!CODE_FETCH_STROBE_N[*8] ##1 CODE_FETCH_STROBE_N))
        else $error("fetch strobe width wrong");
    // standard mode: twelve clocks from latch to strobe end
    cycle_std_a: assert property ($rose(ADDR_LATCH_EN) ##1 ADDR_LATCH_EN |-> ##11 $rose(CODE_FETCH_STROBE_N))
        else $error("standard bus cycle length wrong");
    // double speed: six clocks
    cycle_x2_a: assert property ($rose(ADDR_LATCH_EN) ##1 !ADDR_LATCH_EN |-> ##5 $rose(CODE_FETCH_STROBE_N))
        else $error("double speed bus cycle length wrong");
    // every latch strobe is followed by a fetch strobe
    ale_then_fetch_a: assert property ($fell(ADDR_LATCH_EN) |-> ##[1:2] $fell(CODE_FETCH_STROBE_N))
        else $error("no fetch strobe after latch strobe");

    // main scenarios reached
    std_c: cover property ($rose(ADDR_LATCH_EN) ##1 ADDR_LATCH_EN);
    x2_c: cover property ($rose(ADDR_LATCH_EN) ##1 !ADDR_LATCH_EN);
    fetch_c: cover property ($fell(CODE_FETCH_STROBE_N));
endmodule : cma_assertions

bind cma_top cma_assertions u_chk (
    .CLK_SYS            (CLK_SYS),
    .RST                (RST),
    .LOW_PORT_OUT       (LOW_PORT_OUT),
    .LOW_PORT_OE        (LOW_PORT_OE),
    .HIGH_PORT_OUT      (HIGH_PORT_OUT),
    .ADDR_LATCH_EN      (ADDR_LATCH_EN),
    .CODE_FETCH_STROBE_N(CODE_FETCH_STROBE_N)
);

// >>> bench/cma_ext_mem.sv
// external program memory with its address latch
`timescale 1ns/1ns

module cma_ext_mem (
    // clock
    input  wire logic       clk,
    // bus from the device
    input  wire logic       ale,
    input  wire logic       strobe_n,
    input  wire logic [7:0] low_bus,
    input  wire logic [7:0] high_addr,
    // data back onto the low port
    output logic [7:0]      data_drv
);
    logic [7:0] lat;    // latched low address
    logic [7:0] junk = 8'h00;   // released-port noise

    // transparent latch follows the port while the strobe is up
    always_latch begin
        if (ale) begin
            lat <= low_bus;
        end
    end

    // floating port flips every clock so no stale value passes
    always @(posedge clk) begin
        junk <= ~junk;
    end

    // contents derived from the address, driven only under the strobe
    assign data_drv = !strobe_n ? (lat ^ high_addr ^ 8'h5a) : junk;
endmodule : cma_ext_mem

// >>> bench/tb_top.sv
// self-checking bench of the code memory access block
`timescale 1ns/1ns

module tb_top;
    logic        CLK_SYS = 1'b0, RST = 1'b1;
    logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic        PREADY, PSLVERR;
    logic [15:0] CPU_PC = 16'h0100;
    logic        EXT_ACCESS_SEL = 1'b0;
    logic        PROG_VALID = 1'b0, PROG_PARALLEL = 1'b0;
    logic [1:0]  PROG_TARGET = 2'h0;
    logic [15:0] PROG_ADDR = 16'h0;
    logic [7:0]  PROG_DATA = 8'h0, LOW_PORT_OUT, HIGH_PORT_OUT, mem_drv;
    logic        LOW_PORT_OE, ADDR_LATCH_EN, CODE_FETCH_STROBE_N;
    wire  [7:0]  low_bus = LOW_PORT_OE ? LOW_PORT_OUT : mem_drv;  // resolved port
    logic [31:0] rd;
    logic        err;
    int          n_fail = 0, checks = 0, nlo, nal;

    always #25 CLK_SYS = ~CLK_SYS;  // 20 MHz

    cma_top dut (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CPU_PC(CPU_PC), .EXT_ACCESS_SEL(EXT_ACCESS_SEL), .PROG_VALID(PROG_VALID),
        .PROG_PARALLEL(PROG_PARALLEL), .PROG_TARGET(PROG_TARGET), .PROG_ADDR(PROG_ADDR),
        .PROG_DATA(PROG_DATA), .LOW_PORT_IN(low_bus), .LOW_PORT_OUT(LOW_PORT_OUT),
        .LOW_PORT_OE(LOW_PORT_OE), .HIGH_PORT_OUT(HIGH_PORT_OUT), .ADDR_LATCH_EN(ADDR_LATCH_EN),
        .CODE_FETCH_STROBE_N(CODE_FETCH_STROBE_N));

    cma_ext_mem u_mem (.clk(CLK_SYS), .ale(ADDR_LATCH_EN), .strobe_n(CODE_FETCH_STROBE_N),
        .low_bus(low_bus), .high_addr(HIGH_PORT_OUT), .data_drv(mem_drv));

    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // compare seen against expected
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // one apb transfer, request held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK_SYS);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 16) begin
            n_fail++;
            wrap_up();
        end
    endtask : apb

    // one programmer byte pulse
    task automatic prog(input logic par, input logic [1:0] t, input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        PROG_VALID <= 1'b1;
        PROG_PARALLEL <= par;
        PROG_TARGET <= t;
        PROG_ADDR <= a;
        PROG_DATA <= d;
        @(posedge CLK_SYS);
        PROG_VALID <= 1'b0;
    endtask : prog

    // fetch or constant read, counting strobe clocks on the pins
    task automatic xf(input logic k, input logic [15:0] a);
        apb(1'b1, 12'h008, {16'h0, a});
        apb(1'b1, 12'h010, {31'h0, k});
        nlo = 0;
        nal = 0;
        repeat (24) begin
            @(negedge CLK_SYS);
            nlo += int'(CODE_FETCH_STROBE_N === 1'b0);
            nal += int'(ADDR_LATCH_EN === 1'b1);
        end
        apb(1'b0, 12'h010, 32'h0);
    endtask : xf

    // poll the busy flag until it clears, bounded
    task automatic wait_busy();
        int n;
        n = 0;
        while (rd[0] !== 1'b0 && n < 1200) begin
            apb(1'b0, 12'h004, 32'h0);
            n++;
        end
        chk(32'(n < 1200), 32'h1, "busy clears");
        if (n >= 1200) begin
            wrap_up();
        end
    endtask : wait_busy

    // code byte read through the data window
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string msg);
        apb(1'b1, 12'h008, {16'h0, a});
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, exp, msg);
    endtask : rdc

    initial begin
        repeat (10) @(posedge CLK_SYS);
        RST <= 1'b0;
        // reset values and an unmapped place
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'hf0, "security reset");
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0, "busy reset");
        apb(1'b0, 12'h018, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test reset done");
        // external fetch refused at maximum protection
        xf(1'b0, 16'h1234);
        chk({30'h0, rd[1:0]}, 32'h2, "refused flag");
        chk(32'(nal), 32'd0, "no bus cycle when refused");
        prog(1'b1, 2'h2, 16'h0000, 8'h0f);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'hff, "security low nibble");
        // external fetch in both speeds
        xf(1'b0, 16'h1234);
        chk(32'(nlo), 32'd8, "std strobe clocks");
        chk(32'(nal), 32'd2, "std latch clocks");
        chk({24'h0, rd[15:8]}, 32'h7c, "fetched byte");
        apb(1'b1, 12'h000, 32'h2);
        xf(1'b0, 16'h1234);
        chk(32'(nlo), 32'd4, "x2 strobe clocks");
        apb(1'b1, 12'h000, 32'h0);
        $display("test external bus done");
        // top user address: constant read quiet, fetch goes out
        EXT_ACCESS_SEL <= 1'b1;
        xf(1'b1, 16'h7fff);
        chk(32'(nal), 32'd0, "const read quiet");
        xf(1'b0, 16'h7fff);
        chk(32'(nal), 32'd2, "top fetch prefetch");
        $display("test top address done");
        // programmer port and launch from boot code
        prog(1'b1, 2'h1, 16'hf800, 8'h77);
        prog(1'b0, 2'h0, 16'h0200, 8'h99);
        CPU_PC <= 16'hf800;
        apb(1'b1, 12'h000, 32'h5);
        rdc(16'hf800, 32'h77, "boot byte");
        rdc(16'h0200, 32'h99, "serial byte");
        apb(1'b1, 12'h00c, 32'ha5);
        apb(1'b1, 12'h008, 32'h0123);
        apb(1'b1, 12'h00c, 32'ha5);
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h004, 32'ha0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1, "busy set");
        wait_busy();
        rdc(16'h0123, 32'ha5, "programmed byte");
        rdc(16'h0100, 32'ha5, "last page wins");
        // extra row through the page buffer
        apb(1'b1, 12'h000, 32'hd);
        apb(1'b1, 12'h008, 32'hff85);
        apb(1'b1, 12'h00c, 32'h6e);
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h004, 32'ha0);
        apb(1'b0, 12'h004, 32'h0);
        wait_busy();
        rdc(16'hff85, 32'h6e, "extra row byte");
        // security upper nibble by software, lower nibble kept
        apb(1'b1, 12'h000, 32'h15);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h00c, 32'ha3);
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h004, 32'ha0);
        apb(1'b0, 12'h004, 32'h0);
        wait_busy();
        rdc(16'h0000, 32'haf, "security upper nibble");
        apb(1'b1, 12'h000, 32'h5);
        // intervening write aborts
        apb(1'b1, 12'h00c, 32'h3c);
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h008, 32'h0124);
        apb(1'b1, 12'h004, 32'ha0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0, "aborted launch");
        // user code may not launch nor see boot flash
        CPU_PC <= 16'h0100;
        apb(1'b1, 12'h004, 32'h50);
        apb(1'b1, 12'h004, 32'ha0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0, "user launch ignored");
        rdc(16'hf800, 32'h0, "boot hidden from user");
        rdc(16'h0123, 32'ha5, "user reads user");
        EXT_ACCESS_SEL <= 1'b0;
        rdc(16'h0123, 32'h0, "external code no flash");
        $display("test programming done");
        wrap_up();
    end
endmodule : tb_top

// >>> design/cma_defs.svh
// offsets, field positions, reset values and timing counts of the code memory block
`ifndef CMA_DEFS_SVH
`define CMA_DEFS_SVH

// apb register byte offsets
`define CMA_A_CTRL      12'h000
`define CMA_A_LAUNCH    12'h004
`define CMA_A_ADDR      12'h008
`define CMA_A_DATA      12'h00c
`define CMA_A_XFETCH    12'h010
`define CMA_A_SECURITY  12'h014

// control register fields
`define CMA_C_BOOTMAP   0
`define CMA_C_DOUBLE    1
`define CMA_C_LATCHMAP  2
`define CMA_C_FMOD_LO   3

// launch field codes
`define CMA_LAUNCH_ARM  4'h5
`define CMA_LAUNCH_GO   4'ha

// code space layout
`define CMA_USER_TOP    16'h7fff
`define CMA_BOOT_BASE   16'hf800
`define CMA_PAGE_BYTES  8'h80

// security byte
`define CMA_SEC_FACTORY 8'hf0
`define CMA_SEC_MAXPROT 4'h0

// bus cycle length in oscillator periods
`define CMA_OSC_STD     4'hc
`define CMA_OSC_X2      4'h6

// programming time in system clocks, at least one page
`define CMA_PROG_CYCLES 12'h3e8

`endif

// >>> design/cma_pkg.sv
// types shared by the code memory access block
package cma_pkg;

    // code region the cpu is executing from
    typedef enum logic [1:0] {
        RGN_USER,
        RGN_BOOT,
        RGN_EXT
    } cma_region_t;

    // external bus sequencer
    typedef enum logic {
        XB_IDLE,
        XB_RUN
    } cma_xbus_state_t;

    // launch unlock sequence
    typedef enum logic {
        LN_IDLE,
        LN_ARMED
    } cma_launch_state_t;

    // external programming port request
    typedef struct packed {
        logic        valid;
        logic        parallel;
        logic [1:0]  target;
        logic [15:0] addr;
        logic [7:0]  data;
    } cma_prog_req_t;

endpackage : cma_pkg

// >>> design/cma_top.sv
// code memory access control: external fetch bus, flash arrays, page buffer, launch
`timescale 1ns/1ns
`include "cma_defs.svh"

module cma_top (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output      logic [31:0] PRDATA,
    output      logic        PREADY,
    output      logic        PSLVERR,
    // cpu context
    input  wire logic [15:0] CPU_PC,
    input  wire logic        EXT_ACCESS_SEL,
    // programmer port, parallel or serial in-system
    input  wire logic        PROG_VALID,
    input  wire logic        PROG_PARALLEL,
    input  wire logic [1:0]  PROG_TARGET,
    input  wire logic [15:0] PROG_ADDR,
    input  wire logic [7:0]  PROG_DATA,
    // external code bus
    input  wire logic [7:0]  LOW_PORT_IN,
    output      logic [7:0]  LOW_PORT_OUT,
    output      logic        LOW_PORT_OE,
    output      logic [7:0]  HIGH_PORT_OUT,
    output      logic        ADDR_LATCH_EN,
    output      logic        CODE_FETCH_STROBE_N
);

    // flash arrays and latch data kept across reset; load flags, latch page and security byte are reset
    logic [7:0]  user_flash [0:32767];        // 256 pages of 128 bytes
    logic [7:0]  boot_flash [0:2047];         // boot loader space
    logic [7:0]  extra_row  [0:127];          // separate row
    logic [7:0]  col_latch  [0:127];          // page buffer
    logic [127:0] loaded;                     // ninth bit per latch byte
    logic [7:0]  latch_page;                  // last page address seen
    logic [7:0]  security;                    // hardware security byte

    // software control
    logic        boot_flash_map_enable;
    logic        double_speed_mode;
    logic        latch_map;
    logic [1:0]  fmod;
    logic [15:0] acc_addr;                    // address for data and fetch regs

    // launch and programming
    cma_pkg::cma_launch_state_t launch_st;
    logic        flash_busy_flag;
    logic [11:0] prog_cnt;
    logic [1:0]  prog_fmod;

    // external bus
    cma_pkg::cma_xbus_state_t xb_st;
    logic [3:0]  osc_cnt;
    logic        xb_const;
    logic [7:0]  fetched;
    logic        refused;
    logic [7:0]  low_addr;

    cma_pkg::cma_prog_req_t preq;
    assign preq = '{PROG_VALID, PROG_PARALLEL, PROG_TARGET, PROG_ADDR, PROG_DATA};

    // apb phases
    wire         acc    = PSEL && PENABLE;
    wire         wr     = acc && PWRITE;
    wire         sel_ctrl = PADDR == `CMA_A_CTRL;
    wire         sel_lnch = PADDR == `CMA_A_LAUNCH;
    wire         sel_addr = PADDR == `CMA_A_ADDR;
    wire         sel_data = PADDR == `CMA_A_DATA;
    wire         sel_xf   = PADDR == `CMA_A_XFETCH;
    wire         sel_sec  = PADDR == `CMA_A_SECURITY;
    wire         mapped = sel_ctrl | sel_lnch | sel_addr | sel_data | sel_xf | sel_sec;
    wire [3:0]   launch_field = PWDATA[7:4];

    assign PREADY  = 1'b1;                    // zero wait states
    assign PSLVERR = acc && !mapped;

    // executing region from pc and external access pin
    wire pc_boot = EXT_ACCESS_SEL && boot_flash_map_enable && CPU_PC >= `CMA_BOOT_BASE;
    wire pc_user = EXT_ACCESS_SEL && CPU_PC <= `CMA_USER_TOP;
    cma_pkg::cma_region_t region;
    assign region = pc_boot ? cma_pkg::RGN_BOOT :
                    pc_user ? cma_pkg::RGN_USER : cma_pkg::RGN_EXT;

    // flash read permission
    wire can_read_user = region != cma_pkg::RGN_EXT;
    wire can_read_boot = region == cma_pkg::RGN_BOOT;
    wire can_load      = region != cma_pkg::RGN_EXT && !flash_busy_flag;

    // code space decode of acc_addr; boot window only while mapped
    wire in_user = acc_addr <= `CMA_USER_TOP;
    wire in_boot = boot_flash_map_enable && acc_addr >= `CMA_BOOT_BASE;
    wire [7:0] user_byte = user_flash[acc_addr[14:0]];
    wire [7:0] boot_byte = boot_flash[acc_addr[10:0]];
    wire [7:0] extra_row_byte = extra_row[acc_addr[6:0]];

    // internal code read as selected by block mode
    logic [7:0] code_byte;
    always_comb begin
        code_byte = 8'h00;                    // refused reads give zero
        case (fmod)
            2'h0: begin
                if (in_boot && can_read_boot) begin
                    code_byte = boot_byte;
                end else if (in_user && can_read_user) begin
                    code_byte = user_byte;
                end
            end
            2'h1: begin
                if (can_read_user) begin
                    code_byte = extra_row_byte;
                end
            end
            2'h2: begin
                if (can_read_user) begin
                    code_byte = security;     // both nibbles readable
                end
            end
            default: code_byte = 8'h00;
        endcase
    end

    // external fetch request decode
    wire xf_req   = wr && sel_xf && xb_st == cma_pkg::XB_IDLE;
    wire xf_const = PWDATA[0];
    wire xf_ext   = !EXT_ACCESS_SEL || acc_addr > `CMA_USER_TOP;
    // top internal address fetch leaks a prefetch, constant read does not
    wire xf_go    = xf_ext || (!xf_const && acc_addr == `CMA_USER_TOP);
    // factory protection blocks external execution only
    wire xf_block = !xf_const && xf_ext && security[3:0] == `CMA_SEC_MAXPROT;

    // cycle length: 6 cpu clocks, cpu = osc/2 or osc
    wire [3:0] osc_len = double_speed_mode ? `CMA_OSC_X2 : `CMA_OSC_STD;
    wire [3:0] phase   = double_speed_mode ? osc_cnt : {1'b0, osc_cnt[3:1]};
    wire       xb_run  = xb_st == cma_pkg::XB_RUN;
    wire       xb_last = xb_run && osc_cnt == osc_len - 4'h1;

    // strobes decoded from sequencer registers
    assign ADDR_LATCH_EN       = xb_run && phase == 4'h0;
    assign CODE_FETCH_STROBE_N = !(xb_run && phase >= 4'h2);
    assign LOW_PORT_OE         = xb_run && phase <= 4'h1;  // release before data
    assign LOW_PORT_OUT        = low_addr;

    // launch qualifiers
    wire ln_write = wr && sel_lnch;
    wire ln_fire  = ln_write && launch_st == cma_pkg::LN_ARMED && launch_field == `CMA_LAUNCH_GO;
    // only boot flash code may start programming
    wire ln_ok    = region == cma_pkg::RGN_BOOT && fmod != 2'h3 && !flash_busy_flag;

    // page buffer load strobe and index
    wire       cl_load = wr && sel_data && latch_map && can_load;
    wire [6:0] cl_idx  = acc_addr[6:0];

    // programming engine position
    wire       prog_step = flash_busy_flag && prog_cnt < {4'h0, `CMA_PAGE_BYTES};
    wire [6:0] prog_idx  = prog_cnt[6:0];
    wire       prog_hit  = prog_step && loaded[prog_idx];
    wire [14:0] prog_uaddr = {latch_page, prog_idx};

    // control register and address register writes
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            boot_flash_map_enable <= 1'b0;
            double_speed_mode     <= 1'b0;
            latch_map             <= 1'b0;
            fmod                  <= 2'h0;
            acc_addr              <= 16'h0000;
        end else begin
            if (wr && sel_ctrl) begin
                boot_flash_map_enable <= PWDATA[`CMA_C_BOOTMAP];
                double_speed_mode     <= PWDATA[`CMA_C_DOUBLE];
                latch_map             <= PWDATA[`CMA_C_LATCHMAP];
                fmod                  <= PWDATA[`CMA_C_FMOD_LO +: 2];
            end
            if (wr && sel_addr) begin
                acc_addr <= PWDATA[15:0];
            end
        end
    end

    // unlock sequence: any other write between 5 and A aborts it
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            launch_st <= cma_pkg::LN_IDLE;
        end else if (ln_write && launch_field == `CMA_LAUNCH_ARM) begin
            launch_st <= cma_pkg::LN_ARMED;
        end else if (wr) begin
            launch_st <= cma_pkg::LN_IDLE;    // fire, wrong code or other write
        end
    end

    // busy timer; busy stays up for the whole operation
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            flash_busy_flag <= 1'b0;
            prog_cnt        <= 12'h000;
            prog_fmod       <= 2'h0;
        end else if (ln_fire && ln_ok) begin
            flash_busy_flag <= 1'b1;
            prog_cnt        <= 12'h000;
            prog_fmod       <= fmod;
        end else if (flash_busy_flag) begin
            prog_cnt <= prog_cnt + 12'h001;
            if (prog_cnt == `CMA_PROG_CYCLES - 12'h001) begin
                flash_busy_flag <= 1'b0;
            end
        end
    end

    // page buffer: bytes staged here, flags dropped when programming ends
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            loaded     <= 128'h0;
            latch_page <= 8'h00;
        end else if (cl_load) begin
            loaded[cl_idx] <= 1'b1;
            latch_page     <= acc_addr[14:7];  // last page wins
        end else if (flash_busy_flag && prog_cnt == `CMA_PROG_CYCLES - 12'h001) begin
            loaded <= 128'h0;
        end
    end

    // latch data, no reset: contents only count where flagged
    always_ff @(posedge CLK_SYS) begin
        if (cl_load) begin
            col_latch[cl_idx] <= PWDATA[7:0];
        end
    end

    // array writes from the engine and the programmer port
    always_ff @(posedge CLK_SYS) begin
        if (prog_hit && prog_fmod == 2'h0) begin
            user_flash[prog_uaddr] <= col_latch[prog_idx];
        end else if (preq.valid && preq.target == 2'h0) begin
            user_flash[preq.addr[14:0]] <= preq.data;  // either mode
        end
        if (prog_hit && prog_fmod == 2'h1) begin
            extra_row[prog_idx] <= col_latch[prog_idx];
        end
        if (preq.valid && preq.parallel && preq.target == 2'h1) begin
            boot_flash[preq.addr[10:0]] <= preq.data;  // parallel only
        end
    end

    // security byte: software reaches upper nibble only
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            security <= `CMA_SEC_FACTORY;
        end else if (preq.valid && preq.parallel && preq.target == 2'h2) begin
            security[3:0] <= preq.data[3:0];
        end else if (prog_hit && prog_fmod == 2'h2 && prog_idx == 7'h00) begin
            security[7:4] <= col_latch[0][7:4];
        end
    end

    // external bus sequencer
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            xb_st   <= cma_pkg::XB_IDLE;
            osc_cnt <= 4'h0;
            xb_const <= 1'b0;
            refused <= 1'b0;
        end else if (xb_st == cma_pkg::XB_IDLE) begin
            osc_cnt <= 4'h0;
            if (xf_req) begin
                refused  <= xf_block;
                xb_const <= xf_const;
                if (xf_go && !xf_block) begin
                    xb_st <= cma_pkg::XB_RUN;
                end
            end
        end else if (xb_last) begin
            xb_st <= cma_pkg::XB_IDLE;
        end else begin
            osc_cnt <= osc_cnt + 4'h1;
        end
    end

    // address held on ports for the whole cycle
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            low_addr      <= 8'h00;
            HIGH_PORT_OUT <= 8'h00;
        end else if (xf_req && xf_go && !xf_block) begin
            low_addr      <= acc_addr[7:0];
            HIGH_PORT_OUT <= acc_addr[15:8];
        end
    end

    // data sampled at last oscillator period, port long released
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fetched <= 8'h00;
        end else if (xb_last) begin
            fetched <= LOW_PORT_IN;
        end else if (xf_req && !xf_go) begin
            fetched <= code_byte;             // internal read, constant or fetch
        end
    end

    // read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0;
        case (1'b1)
            sel_ctrl: rdata = {27'h0, fmod, latch_map, double_speed_mode, boot_flash_map_enable};
            sel_lnch: rdata = {31'h0, flash_busy_flag};
            sel_addr: rdata = {16'h0, acc_addr};
            sel_data: rdata = {24'h0, code_byte};
            sel_xf:   rdata = {16'h0, fetched, 5'h0, xb_const, refused, xb_run};
            sel_sec:  rdata = {24'h0, security};
            default:  rdata = 32'h0;
        endcase
    end

    // read data registered at the setup edge, valid in access phase
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rdata;
        end
    end

endmodule : cma_top

// >>> design/cma_top_unused_placeholder.sv
// intentionally empty companion file
`timescale 1ns/1ns
